// ### pkg/sif_pkg.sv
// package: register map, field layout and types of the serial interface
package sif_pkg;
  // =======================================================
  // register byte addresses (printed offsets, one byte apart)
  localparam logic [15:0] ADDR_MODE_ASYNC = 16'hFF70;
  localparam logic [15:0] ADDR_RX_STATUS = 16'hFF71;
  localparam logic [15:0] ADDR_MODE_SYNC = 16'hFF72;
  localparam logic [15:0] ADDR_CLK_DIV = 16'hFF73;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFF74;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hFF75;
  localparam logic [15:0] ADDR_RX_BUF = 16'hFF76;
  localparam logic [15:0] ADDR_PORT = 16'hFF77;
  localparam logic [15:0] ADDR_UNIT = 16'h0004;
  // =======================================================
  // field positions
  localparam int BIT_TX_EN = 7;
  localparam int BIT_RX_EN = 6;
  localparam int BIT_PAR_HI = 5;
  localparam int BIT_PAR_LO = 4;
  localparam int BIT_CHAR_LEN = 3;
  localparam int BIT_STOP_LEN = 2;
  localparam int BIT_TW_EN = 7;
  localparam int BIT_FIRST = 2;
  localparam int BIT_TW_CLK = 1;
  localparam int BIT_PE = 2;
  localparam int BIT_FE = 1;
  localparam int BIT_OVE = 0;
  // =======================================================
  // reset values and masks
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] DIV_WMASK = 8'hF0;
  localparam logic [7:0] ASYNC_WMASK = 8'hFC;
  localparam logic [7:0] SYNC_WMASK = 8'hCF;
  localparam logic [7:0] ERR_MASK = 8'h07;
  localparam logic [3:0] DIV_EXT = 4'h8;
  localparam logic [3:0] DIV_MAX_INT = 4'h7;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [8:0] PRE_ONE = 9'h001;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_e;

  // output and output-enable pair of one two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;

  typedef struct packed {
    logic [7:0] async_mode_config;
    logic [7:0] sync_mode_config;
    logic [7:0] clock_divider_select;
    logic [7:0] rx_error_status;
    logic [7:0] receive_buffer;
    logic rx_full;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [2:0] port_out;
    logic [2:0] port_dir;
    rx_state_e rx_state;
    logic [8:0] pre_cnt;
    logic [3:0] ovs_cnt;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic par_acc;
    logic par_bit_seen;
    logic [1:0] ext_hist;
    logic rd_pend;
    logic [31:0] readdata;
    logic waitreq;
    logic irq;
    pin_drive_s tx_pin;
    pin_drive_s clk_pin;
    pin_drive_s rx_pin;
  } sif_state_s;
endpackage

// ### logic/serial_if_mode_status_baud.sv
// serial interface: mode decode, pin roles, receive error status, divider
// =======================================================
// Contract
// R1 - three-wire mode needs both async enables low; clock source picks pin role
// R2 - async mode needs three-wire fields zero; tx pin CMOS out; ext clock input
// R3 - pins unused by the selected mode keep their port function
// R4 - transmit-only mode leaves the receive pin a normal port pin
// R5 - read-only error status register, readable whole
// R6 - error status has no defined meaning in three-wire mode
// R7 - reset clears error status to zero
// R8 - parity mismatch sets status bit 2
// R9 - missing stop bit sets status bit 1
// R10 - a character finishing before buffer read sets status bit 0
// R11 - receiver checks only the first stop bit
// R12 - overrun repeats on every reception until the buffer is read
// R13 - divider written as a whole byte, reset to zero
// R14 - divider codes 0 to 7 select fx over 2 to the n, n 1 to 8
// R15 - code 8 selects the external clock pin; others prohibited
// R16 - transmit-zero parity setting performs no parity check
// R17 - divider low nibble reads zero and ignores writes
// R18 - all three flags update together per received character
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns
module serial_if_mode_status_baud
  import sif_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe,
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe,
  input wire logic rx_pin_i,
  output logic rx_pin_o,
  output logic rx_pin_oe
);

  sif_state_s q, d;

  // =======================================================
  // helpers
  // n is code plus one, so a tick comes every 2^n clocks
  function automatic logic [8:0] div_limit(input logic [3:0] code);
    div_limit = PRE_ONE << (code + 4'h1);
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  logic tx_en, rx_en, tw_en, async_ok, tw_ok, ext_sel, int_sel, tick;
  logic ext_rise, sample, par_chk, par_err, stop_err, xfer, rd_buf;
  logic [1:0] par_mode;
  logic [3:0] div_code;
  logic [3:0] nbits;
  logic [7:0] err_new, irq_set;

  // =======================================================
  // mode decode
  always_comb begin
    tx_en = q.async_mode_config[BIT_TX_EN];
    rx_en = q.async_mode_config[BIT_RX_EN];
    tw_en = q.sync_mode_config[BIT_TW_EN];
    par_mode = {q.async_mode_config[BIT_PAR_HI],
                q.async_mode_config[BIT_PAR_LO]};
    div_code = q.clock_divider_select[7:4];
    // three-wire legal only with both async enables low
    tw_ok = tw_en && !tx_en && !rx_en; // R1
    // async legal only with three-wire fields all zero
    async_ok = (tx_en || rx_en) && !tw_en &&
               !q.sync_mode_config[BIT_FIRST] &&
               !q.sync_mode_config[BIT_TW_CLK]; // R2
    ext_sel = (div_code == DIV_EXT); // R15
    int_sel = (div_code <= DIV_MAX_INT); // R14
    nbits = q.async_mode_config[BIT_CHAR_LEN] ? BITS_8 : BITS_7;
    par_chk = (par_mode != PAR_NONE) && (par_mode != PAR_ZERO); // R16
    rd_buf = read && !q.waitreq && hit(address, ADDR_RX_BUF);
  end

  // =======================================================
  // next state
  always_comb begin
    d = q;
    tick = 1'b0;
    ext_rise = 1'b0;
    sample = 1'b0;
    xfer = 1'b0;
    par_err = 1'b0;
    stop_err = 1'b0;
    err_new = RST_BYTE;
    irq_set = RST_BYTE;

    // oversample tick: fx/2^n or edge of external clock pin
    d.ext_hist = {q.ext_hist[0], clk_pin_i};
    ext_rise = q.ext_hist[0] && !q.ext_hist[1];
    if (ext_sel) begin
      tick = ext_rise && async_ok; // R15
      d.pre_cnt = PRE_ONE;
    end else if (int_sel) begin
      if (q.pre_cnt >= div_limit(div_code)) begin // R14
        d.pre_cnt = PRE_ONE;
        tick = 1'b1;
      end else begin
        d.pre_cnt = q.pre_cnt + PRE_ONE;
      end
    end

    // receiver, 16 ticks per bit, sampled mid-bit
    if (tick) begin
      d.ovs_cnt = q.ovs_cnt + 4'h1;
    end
    sample = tick && (q.ovs_cnt == OVS_MID);
    unique case (q.rx_state)
      RX_IDLE: begin
        d.ovs_cnt = RST_BYTE[3:0];
        if (async_ok && rx_en && !rx_pin_i) begin
          d.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (sample) begin
          d.rx_state = rx_pin_i ? RX_IDLE : RX_DATA;
          d.bit_cnt = RST_BYTE[3:0];
          d.par_acc = 1'b0;
          d.par_bit_seen = 1'b0;
        end
      end
      RX_DATA: begin
        if (sample) begin
          if (q.bit_cnt < nbits) begin
            d.shift = {rx_pin_i, q.shift[7:1]};
            d.par_acc = q.par_acc ^ rx_pin_i;
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else begin
            d.par_acc = q.par_acc ^ rx_pin_i;
            d.par_bit_seen = 1'b1;
            d.rx_state = RX_STOP;
          end
          if (q.bit_cnt == nbits - 4'h1 && par_mode == PAR_NONE) begin
            d.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        // only the first stop bit is examined
        if (sample) begin // R11
          xfer = 1'b1;
          d.rx_state = RX_IDLE;
        end
      end
    endcase

    // character completion: all flags replaced at once
    if (xfer) begin
      stop_err = !rx_pin_i; // R9
      // odd parity: total ones odd -> acc 1 is good
      par_err = par_chk && q.par_bit_seen &&
                ((par_mode == PAR_ODD) ? !q.par_acc : q.par_acc); // R8
      err_new[BIT_PE] = par_err;
      err_new[BIT_FE] = stop_err;
      err_new[BIT_OVE] = q.rx_full && !rd_buf; // R10 R12
      d.rx_error_status = err_new; // R18
      d.receive_buffer = q.async_mode_config[BIT_CHAR_LEN] ? q.shift :
                         {1'b0, q.shift[7:1]};
      d.rx_full = 1'b1;
      irq_set = err_new;
    end else if (rd_buf) begin
      d.rx_full = 1'b0; // R12
    end

    // avalon slave: one wait cycle, then answer
    d.waitreq = 1'b1;
    d.readdata = RD_ZERO;
    if ((read || write) && q.waitreq && !q.rd_pend) begin
      d.waitreq = 1'b0;
      d.rd_pend = 1'b1;
      if (read) begin
        unique case (1'b1)
          hit(address, ADDR_MODE_ASYNC):
            d.readdata[7:0] = q.async_mode_config;
          hit(address, ADDR_RX_STATUS):
            d.readdata[7:0] = q.rx_error_status; // R5 R6
          hit(address, ADDR_MODE_SYNC):
            d.readdata[7:0] = q.sync_mode_config;
          hit(address, ADDR_CLK_DIV):
            d.readdata[7:0] = q.clock_divider_select; // R17
          hit(address, ADDR_IRQ_STATUS):
            d.readdata[7:0] = q.irq_status;
          hit(address, ADDR_IRQ_MASK):
            d.readdata[7:0] = q.irq_mask;
          hit(address, ADDR_RX_BUF):
            d.readdata[7:0] = q.receive_buffer;
          hit(address, ADDR_PORT):
            d.readdata[7:0] = {2'b00, q.port_dir, q.port_out};
          default:
            d.readdata = RD_ZERO;
        endcase
      end
    end else begin
      d.rd_pend = 1'b0;
    end

    // register writes take effect at the edge of the answer
    if (write && !q.waitreq && byteenable[0]) begin
      if (hit(address, ADDR_MODE_ASYNC)) begin
        d.async_mode_config = writedata[7:0] & ASYNC_WMASK;
      end
      if (hit(address, ADDR_MODE_SYNC)) begin
        d.sync_mode_config = writedata[7:0] & SYNC_WMASK;
      end
      if (hit(address, ADDR_CLK_DIV)) begin
        d.clock_divider_select = writedata[7:0] & DIV_WMASK; // R13 R17
      end
      if (hit(address, ADDR_IRQ_MASK)) begin
        d.irq_mask = writedata[7:0] & ERR_MASK;
      end
      if (hit(address, ADDR_PORT)) begin
        d.port_out = writedata[2:0];
        d.port_dir = writedata[5:3];
      end
    end

    // sticky interrupt status, set wins over write-one-clear
    d.irq_status = q.irq_status;
    if (write && !q.waitreq && byteenable[0] &&
        hit(address, ADDR_IRQ_STATUS)) begin
      d.irq_status = q.irq_status & ~(writedata[7:0] & ERR_MASK);
    end
    d.irq_status = d.irq_status | irq_set;
    d.irq = |(d.irq_status & q.irq_mask);

    // pin roles per mode; unused pins fall back to port function
    d.clk_pin.o = q.port_out[0]; // R3
    d.clk_pin.oe = q.port_dir[0];
    d.tx_pin.o = q.port_out[1];
    d.tx_pin.oe = q.port_dir[1];
    d.rx_pin.o = q.port_out[2]; // R4
    d.rx_pin.oe = q.port_dir[2];
    if (tw_ok) begin
      d.tx_pin.o = q.shift[0];
      d.tx_pin.oe = 1'b1;
      if (q.sync_mode_config[BIT_TW_CLK]) begin // R1
        d.clk_pin.o = q.pre_cnt[0];
        d.clk_pin.oe = 1'b1;
      end else begin
        d.clk_pin.oe = 1'b0;
      end
      d.rx_pin.oe = 1'b0;
    end else if (async_ok) begin
      if (tx_en) begin
        d.tx_pin.o = 1'b1; // idle mark
        d.tx_pin.oe = 1'b1; // R2
      end
      if (rx_en) begin
        d.rx_pin.oe = 1'b0;
      end
      if (ext_sel) begin
        d.clk_pin.oe = 1'b0; // R2
      end
    end
  end

  // =======================================================
  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0; // R7 R13
      q.waitreq <= 1'b1;
      q.pre_cnt <= PRE_ONE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign readdata = q.readdata;
  assign waitrequest = q.waitreq;
  assign irq = q.irq;
  assign clk_pin_o = q.clk_pin.o;
  assign clk_pin_oe = q.clk_pin.oe;
  assign tx_pin_o = q.tx_pin.o;
  assign tx_pin_oe = q.tx_pin.oe;
  assign rx_pin_o = q.rx_pin.o;
  assign rx_pin_oe = q.rx_pin.oe;

  // =======================================================
  // checks
  a_status_upper_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (q.rx_error_status & ~ERR_MASK) == RST_BYTE) // R5
    else $error("status upper bits set");
  a_div_low_zero: assert property (@(posedge clock) disable iff (!rst_n)
    q.clock_divider_select[3:0] == 4'h0) // R17
    else $error("divider low nibble set");
  a_div_write_full: assert property (@(posedge clock) disable iff (!rst_n)
    write && !waitrequest && byteenable[0] && address == ADDR_CLK_DIV
    |=> q.clock_divider_select == ($past(writedata[7:0]) & DIV_WMASK)) // R13
    else $error("divider write lost");
  a_no_par_zero: assert property (@(posedge clock) disable iff (!rst_n)
    par_mode == PAR_ZERO && xfer |=> !q.rx_error_status[BIT_PE]) // R16
    else $error("parity flagged in zero mode");
  a_overrun_set: assert property (@(posedge clock) disable iff (!rst_n)
    xfer && q.rx_full && !rd_buf |=> q.rx_error_status[BIT_OVE]) // R10
    else $error("overrun not flagged");
  a_overrun_repeat: assert property (@(posedge clock) disable iff (!rst_n)
    xfer && !q.rx_full |=> !q.rx_error_status[BIT_OVE]) // R12
    else $error("overrun without full buffer");
  a_frame_err: assert property (@(posedge clock) disable iff (!rst_n)
    xfer && !rx_pin_i |=> q.rx_error_status[BIT_FE]) // R9
    else $error("framing error missed");
  a_flags_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !xfer |=> $stable(q.rx_error_status)) // R18
    else $error("status changed outside completion");
  a_tw_pins: assert property (@(posedge clock) disable iff (!rst_n)
    tw_ok && q.sync_mode_config[BIT_TW_CLK] |=> clk_pin_oe) // R1
    else $error("internal clock not driven");
  a_tx_only_rx: assert property (@(posedge clock) disable iff (!rst_n)
    async_ok && tx_en && !rx_en |=> rx_pin_oe == $past(q.port_dir[2])) // R4
    else $error("rx pin lost port role");
  a_async_tx: assert property (@(posedge clock) disable iff (!rst_n)
    async_ok && tx_en |=> tx_pin_oe) // R2
    else $error("tx pin not driven");
  a_tick_spacing: assert property (@(posedge clock) // R14
    disable iff (!rst_n) tick && int_sel |=> !tick || ext_sel)
    else $error("prescaler tick too soon");
  a_bad_code_quiet: assert property (@(posedge clock) // R15
    disable iff (!rst_n) !int_sel && !ext_sel |-> !tick)
    else $error("tick on prohibited divider code");
  a_ext_edge: assert property (@(posedge clock) // R15
    disable iff (!rst_n) ext_sel && async_ok |-> tick == ext_rise)
    else $error("external tick mismatch");
  a_answer_next: assert property (@(posedge clock)
    disable iff (!rst_n) (read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered");
  a_answer_one: assert property (@(posedge clock)
    disable iff (!rst_n) !waitrequest |=> waitrequest)
    else $error("answer held too long");
  a_readdata_idle: assert property (@(posedge clock)
    disable iff (!rst_n) waitrequest |-> readdata == RD_ZERO)
    else $error("read data outside answer");
  a_rd_clears_full: assert property (@(posedge clock) // R12
    disable iff (!rst_n) rd_buf && !xfer |=> !q.rx_full)
    else $error("buffer read kept full");
  a_xfer_full: assert property (@(posedge clock) // R12
    disable iff (!rst_n) xfer |=> q.rx_full)
    else $error("completed character not held");
  a_stop_good: assert property (@(posedge clock) // R11
    disable iff (!rst_n) xfer && rx_pin_i |=> !q.rx_error_status[BIT_FE])
    else $error("framing error on good stop");
  a_odd_par: assert property (@(posedge clock) // R8
    disable iff (!rst_n) xfer && par_mode == PAR_ODD && q.par_bit_seen &&
    !q.par_acc |=> q.rx_error_status[BIT_PE])
    else $error("odd parity error missed");
  a_even_par: assert property (@(posedge clock) // R8
    disable iff (!rst_n) xfer && par_chk && par_mode != PAR_ODD &&
    q.par_bit_seen && q.par_acc |=> q.rx_error_status[BIT_PE])
    else $error("even parity error missed");
  a_no_par_none: assert property (@(posedge clock) // R16
    disable iff (!rst_n) xfer && !par_chk |=> !q.rx_error_status[BIT_PE])
    else $error("parity flagged without check");
  a_tw_rx_in: assert property (@(posedge clock) // R1
    disable iff (!rst_n) tw_ok |=> !rx_pin_oe)
    else $error("receive pin driven in three-wire mode");
  a_tw_clk_in: assert property (@(posedge clock) // R1
    disable iff (!rst_n) tw_ok && !q.sync_mode_config[BIT_TW_CLK] |=>
    !clk_pin_oe)
    else $error("external clock pin driven");
  a_rx_input: assert property (@(posedge clock) // R2
    disable iff (!rst_n) async_ok && rx_en |=> !rx_pin_oe)
    else $error("receive pin driven in async mode");
  a_ext_clk_in: assert property (@(posedge clock) // R2
    disable iff (!rst_n) async_ok && ext_sel |=> !clk_pin_oe)
    else $error("external clock pin driven in async mode");
  a_idle_ports: assert property (@(posedge clock) // R3
    disable iff (!rst_n) !tw_ok && !async_ok |=>
    tx_pin_oe == $past(q.port_dir[1]))
    else $error("unused tx pin lost port role");
endmodule

// ### verification/uart_far_end.sv
// far-end serial transmitter driving the receive line of the block
`timescale 1ns/1ns
module uart_far_end #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clock,
  output logic line
);
  // =======================================================
  // line idles at mark level between characters
  initial line = 1'b1;

  // =======================================================
  // one character: start, eight data lsb first, parity, one stop
  task send(input logic [7:0] d, input logic p, input logic s);
    logic [10:0] f;
    f = {s, p, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      // a low stop ends early so it cannot pass for the next start bit
      if (i == 10 && !s) begin
        repeat (BIT_CLKS * 3 / 4) @(posedge clock);
      end else begin
        repeat (BIT_CLKS) @(posedge clock);
      end
    end
    line <= 1'b1; // back to idle, next start may follow at once
  endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the serial mode, status and divider block
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  import sif_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] address = 16'h0000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest, irq, rx_line;
  logic clk_pin_o, clk_pin_oe, tx_pin_o, tx_pin_oe, rx_pin_o, rx_pin_oe;
  logic [7:0] q;
  logic ext_clk = 1'b0;
  logic ext_run = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;

  // =======================================================
  // clock, block and far end
  always #10 clock = ~clock;

  // external oversample clock, still unless a test runs it
  always @(posedge clock) begin
    if (ext_run) begin
      ext_clk <= ~ext_clk;
    end
  end

  serial_if_mode_status_baud serial_if_mode_status_baud_i (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .clk_pin_i(ext_clk), .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe),
    .tx_pin_i(tx_pin_o), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
    .rx_pin_i(rx_line), .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe));

  uart_far_end #(.BIT_CLKS(32)) uart_far_end_i (
    .clock(clock), .line(rx_line));

  // =======================================================
  // bus cycle: hold request until waitrequest is sampled low
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d,
           input logic be, output logic [7:0] r);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {24'h000000, d};
    byteenable <= {3'h0, be};
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    // two edges let the registered pins and irq follow a write
    repeat (2) @(posedge clock);
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, 1'b1, r);
  endtask

  task rd(input logic [15:0] a);
    bus(1'b0, a, 8'h00, 1'b0, q);
  endtask

  // one character from the far end, then a short idle gap
  task frame(input logic [7:0] d, input logic p, input logic s);
    uart_far_end_i.send(d, p, s);
    repeat (8) @(posedge clock);
  endtask

  // =======================================================
  // reset values, byte-only divider, read-only status, unmapped
  task t_regs;
    rd(ADDR_RX_STATUS); `CHK("status rst", 8'h00, q)
    rd(ADDR_CLK_DIV); `CHK("div rst", 8'h00, q)
    wr(ADDR_CLK_DIV, 8'h5A);
    rd(ADDR_CLK_DIV); `CHK("div low nibble", 8'h50, q)
    bus(1'b1, ADDR_CLK_DIV, 8'h30, 1'b0, q);
    rd(ADDR_CLK_DIV); `CHK("div partial", 8'h50, q)
    wr(ADDR_RX_STATUS, 8'hFF);
    rd(ADDR_RX_STATUS); `CHK("status ro", 8'h00, q)
    rd(16'hFF80); `CHK("unmapped", 8'h00, q)
    $display("test regs done");
  endtask

  // =======================================================
  // reception errors, overrun repetition, interrupt
  task t_rx;
    wr(ADDR_CLK_DIV, 8'h00); // fastest tick, 32 clocks per bit
    wr(ADDR_MODE_ASYNC, 8'h7C); // rx, even parity, 8 bit, 2 stop
    frame(8'hA5, ^8'hA5, 1'b1);
    rd(ADDR_RX_STATUS); `CHK("clean", 8'h00, q)
    rd(ADDR_RX_BUF); `CHK("data", 8'hA5, q)
    wr(ADDR_IRQ_MASK, 8'h07);
    frame(8'h3C, ~^8'h3C, 1'b1);
    rd(ADDR_RX_STATUS); `CHK("parity", 8'h04, q)
    rd(ADDR_RX_BUF);
    `CHK("irq set", 1'b1, irq)
    frame(8'h5A, ^8'h5A, 1'b0);
    rd(ADDR_RX_STATUS); `CHK("framing", 8'h02, q)
    rd(ADDR_RX_BUF);
    wr(ADDR_IRQ_MASK, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 8'h07);
    `CHK("irq unmasked", 1'b1, irq)
    wr(ADDR_IRQ_STATUS, 8'hFF);
    `CHK("irq cleared", 1'b0, irq)
    // second char starts a quarter bit after first stop: only one stop checked
    frame(8'h11, ^8'h11, 1'b1);
    frame(8'h22, ^8'h22, 1'b1);
    rd(ADDR_RX_STATUS); `CHK("overrun", 8'h01, q)
    frame(8'h33, ^8'h33, 1'b1);
    rd(ADDR_RX_STATUS); `CHK("overrun again", 8'h01, q)
    rd(ADDR_RX_BUF);
    frame(8'h44, ^8'h44, 1'b1);
    rd(ADDR_RX_STATUS); `CHK("after read", 8'h00, q)
    rd(ADDR_RX_BUF); `CHK("data2", 8'h44, q)
    wr(ADDR_MODE_ASYNC, 8'h5C); // transmit-zero parity setting
    frame(8'h55, ~^8'h55, 1'b1);
    rd(ADDR_RX_STATUS); `CHK("no check", 8'h00, q)
    rd(ADDR_RX_BUF);
    $display("test rx done");
  endtask

  // =======================================================
  // external clock pin as source, 7-bit character
  task t_ext;
    wr(ADDR_MODE_ASYNC, 8'h70); // rx, even parity, 7 bit, 1 stop
    ext_run <= 1'b1;
    wr(ADDR_CLK_DIV, 8'h80);
    // parity rides in the eighth data slot, stop in the parity slot
    frame(8'hB4, 1'b1, 1'b1);
    rd(ADDR_RX_STATUS); `CHK("ext status", 8'h00, q)
    rd(ADDR_RX_BUF); `CHK("ext data 7 bit", 8'h34, q)
    ext_run <= 1'b0;
    $display("test ext done");
  endtask

  // =======================================================
  // pin roles per mode
  task t_pins;
    wr(ADDR_MODE_ASYNC, 8'h80);
    `CHK("tx drives", 1'b1, tx_pin_oe)
    wr(ADDR_PORT, 8'h24);
    `CHK("rx port oe", 1'b1, rx_pin_oe)
    `CHK("rx port out", 1'b1, rx_pin_o)
    wr(ADDR_MODE_ASYNC, 8'h00);
    wr(ADDR_MODE_SYNC, 8'h82);
    `CHK("clk out", 1'b1, clk_pin_oe)
    wr(ADDR_MODE_SYNC, 8'h80);
    `CHK("clk in", 1'b0, clk_pin_oe)
    $display("test pins done");
  endtask

  // =======================================================
  // verdict
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog well above the expected run of about 3400 cycles
  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    finish_test;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs;
    t_rx;
    t_ext;
    t_pins;
    finish_test;
  end
endmodule
